/* File: bench/flash_command_sequencer_bench.sv */
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ps
module flash_command_sequencer_bench
  import flash_seq_pkg::*;
;
  localparam logic [7:0] MAKER = 8'hC6; // Arbitrary value
  localparam logic [7:0] PART  = 8'h2D; // Arbitrary value
  localparam logic [7:0] CONT  = 8'h1B; // Arbitrary value
  logic core_clk, rstn, reg_wr, reg_rd, dq_oe, ce_n, we_n, oe_n, frst_n, hv, rb, pend;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, d1, d2;
  logic [31:0] seed = 32'h0000003B;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] dq_out, dq_in;
  logic [31:0] exp_q[$], msk_q[$];
  int err_count = 0;
  int checks = 0;
  flash_command_sequencer dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_reset_n(frst_n), .protect_accel_pin_hv(hv), .ready_busy_pin(rb));
  flash_device_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT), .BUSY(40)) dev_u (.core_clk(core_clk),
    .addr(fa), .dq_wr(dq_out), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(frst_n), .hv(hv),
    .dq_rd(dq_in), .rdy(rb));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Poll status until the masked bits match
  task automatic wst(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, 32'h0, 32'h0);
      n++;
    end while ((rv & m) !== v && n < 400);
    if ((rv & m) !== v) begin
      err_count++;
      $display("wrong value at %0t: status wait ran out", $time);
      complete_run();
    end
  endtask : wst
  task automatic cmd(input op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    wr(REG_CMD, 32'(o));
  endtask : cmd
  task automatic op(input op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cmd(o, a, d);
    wst(32'h3, 32'h2);
  endtask : op
  task automatic rdf(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    op(OP_READ, a, 16'h0);
    rd(REG_RDATA, {16'h0, e}, 32'hFFFF);
  endtask : rdf
  task automatic idr(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    op(OP_ID_READ, a, 16'h0);
    rd(REG_RDATA, {24'h0, e}, 32'hFF);
  endtask : idr
  // Compare each answer whose note has a nonzero mask with the oldest note
  always @(posedge core_clk) begin
    if (pend && msk_q[0] != 0) begin
      checks++;
      if ((reg_rdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        err_count++;
        $display("wrong value at %0t: read %h expected %h", $time, reg_rdata, exp_q[0]);
      end
    end
    if (pend) void'(exp_q.pop_front());
    if (pend) void'(msk_q.pop_front());
    pend <= reg_rd;
  end
  initial begin
    {rstn, reg_wr, reg_rd, pend, reg_addr, reg_wdata} = '0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    rd(REG_STATUS, 32'h0, 32'h78);
    $display("test reset done");
    op(OP_ID_ENTER, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h8, 32'h8);
    for (int i = 0; i < 2; i++) begin
      idr(21'h000000, MAKER);
      idr(21'h000001, PART);
      idr(21'h000003, SECLK_NO);
      idr(21'h01F002, 8'h00);
    end
    repeat (4) idr(21'h000040, CONT);
    idr(21'h000000, MAKER);
    op(OP_RESET, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h0, 32'h8);
    $display("test ident done");
    d1 = rnd();
    d2 = rnd();
    op(OP_PROGRAM, 21'h000123, d1[15:0]);
    rdf(21'h000123, d1[15:0]);
    op(OP_PROGRAM, 21'h000123, d2[15:0]);
    rdf(21'h000123, d1[15:0] & d2[15:0]);
    cmd(OP_PROGRAM, 21'h000200, 16'h0F0F);
    rd(REG_STATUS, 32'h1, 32'h1);
    wr(REG_CMD, 32'(OP_ID_ENTER));
    wst(32'h3, 32'h2);
    rd(REG_STATUS, 32'h40, 32'h48);
    rdf(21'h000200, 16'h0F0F);
    wr(REG_STATUS, 32'h0);
    cmd(OP_PROGRAM, 21'h000300, 16'h0000);
    wst(32'h2, 32'h0);
    wr(REG_STATUS, 32'h80000000);
    wst(32'h3, 32'h2);
    rdf(21'h000300, 16'hFFFF);
    $display("test program done");
    op(OP_BYP_ENTER, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h20, 32'h20);
    for (int i = 0; i < 2; i++) op(OP_BYP_PROGRAM, 21'h400 + 21'(i), 16'hA5C3 >> i);
    op(OP_ID_ENTER, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h60, 32'h68);
    wr(REG_STATUS, 32'h0);
    op(OP_BYP_EXIT, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h0, 32'h20);
    rdf(21'h000400, 16'hA5C3);
    rdf(21'h000401, 16'h52E1);
    op(OP_POLL, 21'h000401, 16'h0);
    rd(REG_STATUS, 32'h4, 32'h4);
    op(OP_RESET, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h0, 32'h4);
    op(OP_SEC_ENTER, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h10, 32'h10);
    op(OP_BYP_ENTER, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h50, 32'h70);
    wr(REG_STATUS, 32'h0);
    op(OP_SEC_EXIT, 21'h0, 16'h0);
    rd(REG_STATUS, 32'h0, 32'h10);
    wr(REG_STATUS, 32'h20);
    rd(REG_STATUS, 32'h20, 32'h20);
    op(OP_BYP_PROGRAM, 21'h000500, d2[31:16]);
    wr(REG_STATUS, 32'h0);
    op(OP_BYP_EXIT, 21'h0, 16'h0);
    rdf(21'h000500, d2[31:16]);
    $display("test bypass done");
    op(OP_CHIP_ERASE, 21'h0, 16'h0);
    rdf(21'h000123, 16'hFFFF);
    rdf(21'h000400, 16'hFFFF);
    $display("test erase done");
    complete_run();
  end
endmodule : flash_command_sequencer_bench

/* File: bench/flash_device_model.sv */
// Behavioural flash device answering the sequencer pins
`timescale 1ns/1ps
module flash_device_model
  import flash_seq_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5C, // Arbitrary value
  parameter logic [7:0] PART  = 8'hB3, // Arbitrary value
  parameter logic [7:0] CONT  = 8'h3E, // Arbitrary value
  parameter int         BUSY  = 40     // Embedded run time
)(
  input  wire logic              core_clk, // Clock
  input  wire logic [ADDR_W-1:0] addr,     // Address pins
  input  wire logic [DATA_W-1:0] dq_wr,    // Host data
  input  wire logic              ce_n,     // Chip enable
  input  wire logic              we_n,     // Write enable
  input  wire logic              oe_n,     // Output enable
  input  wire logic              reset_n,  // Hardware reset
  input  wire logic              hv,       // High voltage
  output logic      [DATA_W-1:0] dq_rd,    // Device data
  output logic                   rdy       // Ready high
);
  logic [15:0]       mem [int];
  int                step = 0;
  int                busy = 0;
  logic [1:0]        mode = 2'h0; // Read, ident, security, bypass
  logic              we_q = 1'b1;
  logic              ce_q = 1'b1; // Select seen with the write pulse
  logic              hv_q = 1'b0;
  logic              tog  = 1'b0;
  logic              ers  = 1'b0;
  logic [ADDR_W-1:0] pa   = '0;
  logic [15:0]       pd   = '0;
  logic [15:0]       last = '0;
  initial dq_rd = '0;
  initial rdy = 1'b1;
  function automatic logic [15:0] get(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction : get
  // Read answer by mode
  function automatic logic [15:0] rdv(input logic [ADDR_W-1:0] a);
    if (busy != 0) return {9'h0, tog, 6'h0};
    if (mode != 2'h1) return get(a);
    case (a[7:0])
      ID_MAKER_OFS: return {8'h0, MAKER};
      ID_PART_OFS:  return {8'h0, PART};
      ID_SECLK_OFS: return {8'h0, SECLK_NO};
      ID_CONT_OFS:  return {8'h0, CONT};
      default:      return 16'h0000;
    endcase
  endfunction : rdv
  // Command decoder for one write cycle
  task automatic wcyc(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic       u1;
    c = d[7:0];
    u1 = (a == UNLOCK_ADDR1);
    if (c == CMD_RESET && step != 8 && mode != 2'h3) begin
      step = 0;
      if (mode == 2'h1) mode = 2'h0;
    end else case (step)
      0: if (mode == 2'h3) step = c == CMD_PROGRAM ? 8 : c == CMD_IDENT ? 9 : 0;
         else step = (u1 && c == UNLOCK_DATA1) ? 1 : 0;
      1, 4: step = (a == UNLOCK_ADDR2 && c == UNLOCK_DATA2) ? step + 1 : 0;
      3: step = (u1 && c == UNLOCK_DATA1) ? 4 : 0;
      2: begin
        step = 0;
        if (u1 && c == CMD_IDENT && mode == 2'h2) step = 9;
        else if (u1 && c == CMD_IDENT && mode == 2'h0) mode = 2'h1;
        else if (u1 && c == CMD_SEC_ENTER) mode = 2'h2;
        else if (u1 && c == CMD_PROGRAM) step = 8;
        else if (u1 && c == CMD_BYPASS && mode == 2'h0) mode = 2'h3;
        else if (u1 && c == CMD_ERASE_SET) step = 3;
      end
      5: begin
        step = 0;
        ers = 1'b1;
        if (u1 && c == CMD_CHIP_ERS) busy = BUSY;
      end
      8: begin
        {step, pa, pd, ers, busy} = {32'd0, a, d, 1'b0, BUSY};
      end
      default: begin
        step = 0;
        if (c == CMD_ZERO) mode = 2'h0;
      end
    endcase
  endtask : wcyc
  // Embedded run, reset abort, write decode and read drive
  always @(posedge core_clk) begin
    if (!reset_n) {busy, step, mode} = {32'd0, 32'd0, 2'h0};
    else begin
      if (busy == 1 && ers) mem.delete();
      else if (busy == 1) mem[int'(pa)] = get(pa) & pd;
      if (busy > 0) busy = busy - 1;
      if (hv && !hv_q && mode == 2'h0) mode = 2'h3;
      if (we_n && !we_q && !ce_q && busy == 0) wcyc(addr, dq_wr);
    end
    if (!ce_n && !oe_n) begin
      dq_rd <= rdv(addr);
      last <= rdv(addr);
      tog <= ~tog;
    end else dq_rd <= ~last;
    we_q <= we_n;
    ce_q <= ce_n;
    hv_q <= hv;
    rdy <= (busy == 0);
  end
endmodule : flash_device_model

/* File: bench/flash_seq_monitor.sv */
// Checker of flash pin and register port timing
`timescale 1ns/1ps
module flash_seq_monitor
  import flash_seq_pkg::*;
(
  input wire logic              core_clk,     // Clock
  input wire logic              rstn,         // Reset
  input wire logic              reg_rd,       // Read strobe
  input wire logic [31:0]       reg_rdata,    // Read data
  input wire logic [ADDR_W-1:0] flash_addr,   // Address pins
  input wire logic [DATA_W-1:0] flash_dq_out, // Data driven
  input wire logic              flash_dq_oe,  // Data enable
  input wire logic              flash_ce_n,   // Chip enable
  input wire logic              flash_we_n,   // Write enable
  input wire logic              flash_oe_n,   // Output enable
  input wire logic              flash_reset_n // Hardware reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Pulse shapes of one device bus cycle
  sequence we_pulse_s; !flash_we_n [*7] ##1 flash_we_n; endsequence
  sequence we_rec_s; flash_we_n [*4]; endsequence
  sequence oe_pulse_s; !flash_oe_n [*8]; endsequence
  rd_answer_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  we_width_a: assert property ($fell(flash_we_n) |-> we_pulse_s)
    else $error("write pulse not seven cycles");
  we_recover_a: assert property ($rose(flash_we_n) |-> we_rec_s)
    else $error("write recovery too short");
  oe_width_a: assert property ($fell(flash_oe_n) |-> oe_pulse_s)
    else $error("read pulse too short");
  no_contention_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
    else $error("data pins driven during read");
  we_select_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write without select or data");
  we_stable_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write");
  rst_pulse_a: assert property ($fell(flash_reset_n) |=> flash_reset_n)
    else $error("hardware reset not one cycle");
endmodule : flash_seq_monitor
bind flash_command_sequencer flash_seq_monitor mon_u (.core_clk(core_clk), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n));

/* File: hw/flash_command_sequencer.sv */
// Host-side controller that drives flash command sequences over the device pins
`timescale 1ns/1ps
module flash_command_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic              core_clk,       // System clock
  input  wire logic              rstn,           // Async reset, active low
  input  wire logic [3:0]        reg_addr,       // Register address
  input  wire logic [31:0]       reg_wdata,      // Register write data
  input  wire logic              reg_wr,         // Write strobe
  input  wire logic              reg_rd,         // Read strobe
  output logic      [31:0]       reg_rdata,      // Read data, next cycle
  output logic      [ADDR_W-1:0] flash_addr,     // Device address pins
  output logic      [DATA_W-1:0] flash_dq_out,   // Data pins driven
  output logic                   flash_dq_oe,    // Data pins enable
  input  wire logic [DATA_W-1:0] flash_dq_in,    // Data pins sampled
  output logic                   flash_ce_n,     // Chip enable
  output logic                   flash_we_n,     // Write enable
  output logic                   flash_oe_n,     // Output enable
  output logic                   flash_reset_n,  // Hardware reset
  output logic                   protect_accel_pin_hv, // Request high voltage level
  input  wire logic              ready_busy_pin  // Ready high, busy low
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WE, S_RD, S_REC, S_NEXT} st_t;
  typedef enum logic [1:0] {M_READ, M_IDENT, M_SEC, M_BYP} mode_t;

  // Builds the i-th bus cycle of a sequence
  function automatic bus_cycle_t seq_cycle(input op_t op, input logic [2:0] i,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_cycle_t c;
    c = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: {8'h00, UNLOCK_DATA1}};
    if (i == 3'd1 || i == 3'd4) c = '{wr: 1'b1, addr: UNLOCK_ADDR2, data: {8'h00, UNLOCK_DATA2}};
    unique case (op)
      OP_RESET:       c = '{wr: 1'b1, addr: a, data: {8'h00, CMD_RESET}};
      OP_READ,
      OP_POLL:        c = '{wr: 1'b0, addr: a, data: '0};
      OP_ID_ENTER:    if (i == 3'd2) c.data = {8'h00, CMD_IDENT};
      OP_ID_READ:     c = '{wr: 1'b0, addr: a, data: '0};
      OP_SEC_ENTER:   if (i == 3'd2) c.data = {8'h00, CMD_SEC_ENTER};
      OP_SEC_EXIT: begin
        if (i == 3'd2) c.data = {8'h00, CMD_IDENT};
        if (i == 3'd3) c = '{wr: 1'b1, addr: a, data: {8'h00, CMD_ZERO}};
      end
      OP_PROGRAM: begin
        if (i == 3'd2) c.data = {8'h00, CMD_PROGRAM};
        if (i == 3'd3) c = '{wr: 1'b1, addr: a, data: d};
      end
      OP_BYP_ENTER:   if (i == 3'd2) c.data = {8'h00, CMD_BYPASS};
      OP_BYP_PROGRAM: c = (i == 3'd0) ? bus_cycle_t'{wr: 1'b1, addr: a, data: {8'h00, CMD_PROGRAM}}
                                      : bus_cycle_t'{wr: 1'b1, addr: a, data: d};
      OP_BYP_EXIT:    c = (i == 3'd0) ? bus_cycle_t'{wr: 1'b1, addr: a, data: {8'h00, CMD_IDENT}}
                                      : bus_cycle_t'{wr: 1'b1, addr: a, data: {8'h00, CMD_ZERO}};
      OP_CHIP_ERASE: begin
        if (i == 3'd2) c.data = {8'h00, CMD_ERASE_SET};
        if (i == 3'd5) c.data = {8'h00, CMD_CHIP_ERS};
      end
      default:        c = '{wr: 1'b0, addr: a, data: '0};
    endcase
    return c;
  endfunction : seq_cycle

  // Number of bus cycles per operation
  function automatic logic [2:0] seq_len(input op_t op);
    unique case (op)
      OP_ID_ENTER, OP_SEC_ENTER, OP_BYP_ENTER: return 3'd3;
      OP_SEC_EXIT, OP_PROGRAM:                 return 3'd4;
      OP_BYP_PROGRAM, OP_BYP_EXIT:             return 3'd2;
      OP_CHIP_ERASE:                           return 3'd6;
      default:                                 return 3'd1;
    endcase
  endfunction : seq_len

  // Two-flop synchronisers for pin inputs
  logic [DATA_W-1:0] dq_s1, dq_s2;
  logic              rb_s1, rb_s2;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_pin;
      rb_s2 <= rb_s1;
    end
  end

  st_t               state, next_state;
  mode_t             mode, next_mode;
  op_t               op, next_op;
  logic [2:0]        idx, next_idx;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [ADDR_W-1:0] arg_addr, next_arg_addr;
  logic [DATA_W-1:0] arg_data, next_arg_data;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic              busy, next_busy;
  logic              rej, next_rej;
  logic              done, next_done;
  logic              to_flag, next_to_flag;
  logic              accel, next_accel;
  logic              next_hw_rst;
  logic [31:0]       next_reg_rdata;
  bus_cycle_t        cur;
  logic              allowed;
  op_t               req_op;

  assign req_op = op_t'(reg_wdata[3:0]);
  assign cur    = seq_cycle(op, idx, arg_addr, arg_data);

  // Legality check of a requested operation against the tracked device mode
  always_comb begin
    allowed = 1'b1;
    if (!rb_s2 && !(req_op inside {OP_POLL, OP_READ})) allowed = 1'b0;
    if (mode == M_BYP && !(req_op inside {OP_BYP_PROGRAM, OP_BYP_EXIT, OP_READ, OP_POLL}))
      allowed = 1'b0;
    if (mode != M_BYP && req_op inside {OP_BYP_PROGRAM, OP_BYP_EXIT}) allowed = 1'b0;
    if (mode == M_SEC && req_op == OP_BYP_ENTER) allowed = 1'b0;
    if (mode != M_READ && req_op == OP_ID_ENTER) allowed = 1'b0;
    if (mode != M_IDENT && req_op == OP_ID_READ) allowed = 1'b0;
    if (mode != M_SEC && req_op == OP_SEC_EXIT) allowed = 1'b0;
    if (mode != M_READ && req_op == OP_SEC_ENTER) allowed = 1'b0;
  end

  // Sequencer next-state logic
  always_comb begin
    next_state    = state;
    next_mode     = mode;
    next_op       = op;
    next_idx      = idx;
    next_cnt      = cnt;
    next_arg_addr = arg_addr;
    next_arg_data = arg_data;
    next_rdata    = rdata;
    next_busy     = busy;
    next_rej      = rej;
    next_done     = done;
    next_to_flag  = to_flag;
    next_accel    = accel;
    next_hw_rst   = 1'b0;
    if (reg_wr && reg_addr == REG_ADDR) next_arg_addr = reg_wdata[ADDR_W-1:0];
    if (reg_wr && reg_addr == REG_WDATA) next_arg_data = reg_wdata[DATA_W-1:0];
    if (reg_wr && reg_addr == REG_STATUS) begin
      next_accel  = reg_wdata[ST_BYPM] & (mode != M_SEC);
      next_hw_rst = reg_wdata[31];
      next_rej    = 1'b0;
      next_done   = 1'b0;
      if (reg_wdata[ST_BYPM] && mode == M_READ) next_mode = M_BYP;
    end
    // A command written while a sequence runs is dropped and flagged
    if (reg_wr && reg_addr == REG_CMD && state != S_IDLE) next_rej = 1'b1;
    unique case (state)
      S_IDLE: begin
        if (reg_wr && reg_addr == REG_CMD) begin
          if (allowed && !busy) begin
            next_op    = req_op;
            next_idx   = '0;
            next_state = S_SETUP;
            next_busy  = 1'b1;
          end else begin
            next_rej = 1'b1;
          end
        end
      end
      S_SETUP: begin
        next_cnt   = cur.wr ? CNT_W'(WE_CYC) : CNT_W'(RD_CYC);
        next_state = cur.wr ? S_WE : S_RD;
      end
      S_WE: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_W'(1)) begin
          next_cnt   = CNT_W'(REC_CYC);
          next_state = S_REC;
        end
      end
      S_RD: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_W'(1)) begin
          next_rdata = dq_s2;
          if (op == OP_POLL) next_to_flag = dq_s2[TIMEOUT_POS];
          next_cnt   = CNT_W'(REC_CYC);
          next_state = S_REC;
        end
      end
      S_REC: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_W'(1)) next_state = S_NEXT;
      end
      S_NEXT: begin
        if (idx + 3'd1 < seq_len(op)) begin
          next_idx   = idx + 3'd1;
          next_state = S_SETUP;
        end else begin
          next_state = S_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          unique case (op)
            OP_ID_ENTER:  next_mode = M_IDENT;
            OP_SEC_ENTER: next_mode = M_SEC;
            OP_BYP_ENTER: next_mode = M_BYP;
            OP_SEC_EXIT:  next_mode = M_READ;
            OP_BYP_EXIT:  next_mode = accel ? M_BYP : M_READ;
            OP_RESET: begin
              next_mode    = (mode == M_IDENT) ? M_READ : mode;
              next_to_flag = 1'b0;
            end
            default:      next_mode = mode;
          endcase
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (next_hw_rst) begin
      next_state = S_IDLE;
      next_busy  = 1'b0;
      next_mode  = accel ? M_BYP : M_READ;
    end
  end

  // Register readback
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CMD:    next_reg_rdata = {28'h0000000, op};
        REG_ADDR:   next_reg_rdata = {{(32-ADDR_W){1'b0}}, arg_addr};
        REG_WDATA:  next_reg_rdata = {16'h0000, arg_data};
        REG_STATUS: next_reg_rdata = {24'h000000, done, rej, mode == M_BYP, mode == M_SEC,
                                      mode == M_IDENT, to_flag, rb_s2, busy};
        REG_RDATA:  next_reg_rdata = {16'h0000, rdata};
        default:    next_reg_rdata = '0;
      endcase
    end
  end

  // State registers and pin drivers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= S_IDLE;
      mode          <= M_READ;
      op            <= OP_READ;
      idx           <= '0;
      cnt           <= '0;
      arg_addr      <= '0;
      arg_data      <= '0;
      rdata         <= '0;
      busy          <= 1'b0;
      rej           <= 1'b0;
      done          <= 1'b0;
      to_flag       <= 1'b0;
      accel         <= 1'b0;
      reg_rdata     <= '0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_reset_n <= 1'b0;
      protect_accel_pin_hv <= 1'b0;
    end else begin
      state         <= next_state;
      mode          <= next_mode;
      op            <= next_op;
      idx           <= next_idx;
      cnt           <= next_cnt;
      arg_addr      <= next_arg_addr;
      arg_data      <= next_arg_data;
      rdata         <= next_rdata;
      busy          <= next_busy;
      rej           <= next_rej;
      done          <= next_done;
      to_flag       <= next_to_flag;
      accel         <= next_accel;
      reg_rdata     <= next_reg_rdata;
      flash_addr    <= cur.addr;
      flash_dq_out  <= cur.data;
      flash_dq_oe   <= (next_state == S_WE) || (next_state == S_REC && cur.wr);
      flash_ce_n    <= !(next_state == S_WE || next_state == S_RD);
      flash_we_n    <= !(next_state == S_WE);
      flash_oe_n    <= !(next_state == S_RD);
      flash_reset_n <= !next_hw_rst;
      protect_accel_pin_hv <= next_accel;
    end
  end

endmodule : flash_command_sequencer

/* File: hw/flash_seq_pkg.sv */
// Package: command codes, addresses, timing and carriers for the flash command sequencer
package flash_seq_pkg;
  // Host-side bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  // Word-mode unlock addresses and command data
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002AA;
  localparam logic [7:0] UNLOCK_DATA1  = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2  = 8'h55;
  localparam logic [7:0] CMD_IDENT     = 8'h90;
  localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
  localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0] CMD_BYPASS    = 8'h20;
  localparam logic [7:0] CMD_ERASE_SET = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERS  = 8'h10;
  localparam logic [7:0] CMD_RESET     = 8'hF0;
  localparam logic [7:0] CMD_ZERO      = 8'h00;
  // Identification offsets
  localparam logic [7:0] ID_MAKER_OFS  = 8'h00;
  localparam logic [7:0] ID_PART_OFS   = 8'h01;
  localparam logic [7:0] ID_PROT_OFS   = 8'h02;
  localparam logic [7:0] ID_SECLK_OFS  = 8'h03;
  localparam logic [7:0] ID_CONT_OFS   = 8'h40;
  localparam logic [7:0] SECLK_YES     = 8'h99;
  localparam logic [7:0] SECLK_NO      = 8'h19;
  // Status bit positions
  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_POS    = 6;
  localparam int TIMEOUT_POS   = 5;
  // Bus timing at 125 MHz
  localparam int CLK_PS       = 8000;
  localparam int T_WE_LOW_NS  = 50;
  localparam int T_RD_ACC_NS  = 120;
  localparam int T_REC_NS     = 30;
  localparam int WE_CYC  = (T_WE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_CYC  = (T_RD_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W   = 8;
  // Software register offsets
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  // Status register field positions
  localparam int ST_BUSY = 0;
  localparam int ST_RDY  = 1;
  localparam int ST_TO   = 2;
  localparam int ST_IDM  = 3;
  localparam int ST_SECM = 4;
  localparam int ST_BYPM = 5;
  localparam int ST_REJ  = 6;
  localparam int ST_DONE = 7;
  // Host operations ordered through the command register
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_ID_ENTER, OP_ID_READ, OP_SEC_ENTER, OP_SEC_EXIT,
    OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROGRAM, OP_BYP_EXIT, OP_CHIP_ERASE, OP_POLL
  } op_t;
  // One device bus cycle
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_cycle_t;
endpackage : flash_seq_pkg
